//--- scd_regs.svh
// register offsets, field positions, reset values and timing counts of the clock configuration block
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH
`define SCD_OFF_RCC 8'h00
`define SCD_OFF_RUN_CLOCK_CONFIG_EXT 8'h04
`define SCD_OFF_XLAT 8'h08
`define SCD_OFF_STAT 8'h0c
`define SCD_OFF_GATE 8'h10
// run_clock_config fields
`define SCD_RCC_OSC 4
`define SCD_RCC_CRYSTAL_SELECT 6
`define SCD_RCC_BYP 11
`define SCD_RCC_PWRDN 13
`define SCD_RCC_PWM_CLOCK_DIVIDER 17
`define SCD_RCC_PWMEN 20
`define SCD_RCC_USEDIV 22
`define SCD_RCC_SYSTEM_DIVIDER 23
`define SCD_RCC_WMASK 32'h07de_2ff0
`define SCD_RCC_RST 32'h0786_2ec0
// run_clock_config_ext fields
`define SCD_RUN_CLOCK_CONFIG_EXT_OSC 4
`define SCD_RUN_CLOCK_CONFIG_EXT_BYP 11
`define SCD_RUN_CLOCK_CONFIG_EXT_PWRDN 13
`define SCD_RUN_CLOCK_CONFIG_EXT_SYSTEM_DIVIDER 23
`define SCD_RUN_CLOCK_CONFIG_EXT_OVR 31
`define SCD_RUN_CLOCK_CONFIG_EXT_WMASK 32'h9f80_2870
`define SCD_RUN_CLOCK_CONFIG_EXT_RST 32'h07c0_2810
`define SCD_GATE_RST 8'hff
// timing
`define SCD_RELOCK_LOAD 16'h1200
`define SCD_VCO_MHZ 400
`define SCD_ADC_MHZ 16
`define SCD_ADC_DIV (`SCD_VCO_MHZ / `SCD_ADC_MHZ)
`define SCD_OSC_RTC 3'h7
`endif

//--- scd_pkg.sv
// types shared by the clock configuration block
package scd_pkg;
	typedef enum logic [2:0] {
		SCD_PLL_OFF = 3'b001,
		SCD_PLL_RELOCK = 3'b010,
		SCD_PLL_LOCKED = 3'b100
	} scd_pll_state_t;
	typedef struct packed {
		logic sys;
		logic adc;
		logic pwm;
	} scd_ticks_t;
endpackage

//--- scd_clock_config.sv
// run-mode system clock configuration, dividers, relock guard and peripheral gating
// Summary of operation
// - override bit set makes ext register fields replace the overlapping base fields
// - adc clock is pll vco divided to 16 MHz regardless of system clock
// - pwm clock is a synchronous division of system clock by pwm divider field
// - system divider applies to pll output, or to the oscillator when bypassed
// - base divisor equals the 4-bit divider field plus one
// - pll vco output is halved before the system divisor
// - ext divider field is six bits, divisors up to 64
// - ext divisor is field plus one, on halved pll or raw source per ext bypass
// - crystal select is translated in hardware into pll settings
// - the translation is readable by software
// - each crystal change recomputes translation and updates pll settings
// - pll stays powered down after reset until software enables it
// - ext oscillator code 7 makes the 32 kHz rtc the pll reference
// - peripherals run from system clock, each gated by its own enable
// - pll change starts a 0x1200 count on main oscillator; no pll use before expiry
// - pll enable and select in one write keeps oscillator until relock ends
// - rewriting the same crystal value starts no relock
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`include "scd_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module scd_clock_config #(
	parameter int NPERIPH = 8,
	parameter logic [15:0] RELOCK_LOAD = `SCD_RELOCK_LOAD
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic main_osc_i,
	input wire logic int_osc_i,
	input wire logic slow_osc_i,
	input wire logic rtc_osc_i,
	input wire logic pll_vco_i,
	output scd_pkg::scd_ticks_t ticks_o,
	output logic [NPERIPH-1:0] periph_clk_en_o,
	output logic pll_enable_o,
	output logic pll_ref_rtc_o,
	output logic use_pll_o,
	output logic [13:0] pll_settings_o
);
	// crystal code to pll settings {feedback, reference}, one entry per code
	localparam logic [13:0] XLAT [16] = '{14'h0c80, 14'h0c81, 14'h0c82, 14'h0c83,
		14'h0a43, 14'h0c85, 14'h0b05, 14'h0c86, 14'h0b46, 14'h0c47, 14'h0c88,
		14'h0ba8, 14'h0c09, 14'h0c8a, 14'h0c4b, 14'h0c4c};
	localparam logic [4:0] ADC_DIV = 5'(`SCD_ADC_DIV);

	// pin synchronisers; stage three only feeds edge detection
	logic [4:0] pin_raw, s1_reg, s2_reg, s3_reg, edge_w;
	assign pin_raw = {pll_vco_i, rtc_osc_i, slow_osc_i, int_osc_i, main_osc_i};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg <= 5'h00;
			s2_reg <= 5'h00;
			s3_reg <= 5'h00;
		end else begin
			s1_reg <= pin_raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_edge
			assign edge_w[gi] = s2_reg[gi] & ~s3_reg[gi];
		end
	endgenerate

	// register file
	logic [31:0] rcc_reg, rcc_next, run_clock_config_ext_reg, run_clock_config_ext_next, rd_reg, rd_next;
	logic [NPERIPH-1:0] gate_reg, gate_next;
	logic ack_reg, ack_next, wr_rcc, wr_go;
	logic [31:0] bmask;
	scd_pkg::scd_pll_state_t st_reg, st_next;
	logic [15:0] cnt_reg, cnt_next;
	assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg;
	assign wr_rcc = wr_go & (wb_adr_i == `SCD_OFF_RCC);
	assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	always_comb begin
		rcc_next = rcc_reg;
		run_clock_config_ext_next = run_clock_config_ext_reg;
		gate_next = gate_reg;
		rd_next = 32'h0000_0000;
		ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
		if (wr_rcc) begin
			rcc_next = (rcc_reg & ~(bmask & `SCD_RCC_WMASK)) | (wb_dat_i & bmask & `SCD_RCC_WMASK);
		end
		if (wr_go && wb_adr_i == `SCD_OFF_RUN_CLOCK_CONFIG_EXT) begin
			run_clock_config_ext_next = (run_clock_config_ext_reg & ~(bmask & `SCD_RUN_CLOCK_CONFIG_EXT_WMASK)) | (wb_dat_i & bmask & `SCD_RUN_CLOCK_CONFIG_EXT_WMASK);
		end
		if (wr_go && wb_adr_i == `SCD_OFF_GATE) begin
			gate_next = (gate_reg & ~bmask[NPERIPH-1:0]) | (wb_dat_i[NPERIPH-1:0] & bmask[NPERIPH-1:0]);
		end
		unique case (wb_adr_i)
			`SCD_OFF_RCC: rd_next = rcc_reg;
			`SCD_OFF_RUN_CLOCK_CONFIG_EXT: rd_next = run_clock_config_ext_reg;
			`SCD_OFF_XLAT: rd_next = {18'h00000, pll_settings_o};
			`SCD_OFF_STAT: rd_next = {29'h0000_0000, use_pll_o, st_reg == scd_pkg::SCD_PLL_RELOCK,
				st_reg == scd_pkg::SCD_PLL_LOCKED};
			`SCD_OFF_GATE: rd_next = 32'(gate_reg);
			default: rd_next = 32'h0000_0000; // unmapped reads zero, writes dropped
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rcc_reg <= `SCD_RCC_RST;
			run_clock_config_ext_reg <= `SCD_RUN_CLOCK_CONFIG_EXT_RST;
			gate_reg <= NPERIPH'(`SCD_GATE_RST);
			rd_reg <= 32'h0000_0000;
			ack_reg <= 1'b0;
		end else begin
			rcc_reg <= rcc_next;
			run_clock_config_ext_reg <= run_clock_config_ext_next;
			gate_reg <= gate_next;
			rd_reg <= rd_next;
			ack_reg <= ack_next;
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rd_reg;

	// effective fields after the override choice
	logic ovr, e_byp, e_pwrdn;
	logic [2:0] e_osc;
	logic [6:0] e_div;
	logic [3:0] crystal_select, crystal_select_new;
	assign ovr = run_clock_config_ext_reg[`SCD_RUN_CLOCK_CONFIG_EXT_OVR];
	assign crystal_select = rcc_reg[`SCD_RCC_CRYSTAL_SELECT +: 4];
	assign crystal_select_new = rcc_next[`SCD_RCC_CRYSTAL_SELECT +: 4];
	always_comb begin
		if (ovr) begin
			e_byp = run_clock_config_ext_reg[`SCD_RUN_CLOCK_CONFIG_EXT_BYP];
			e_pwrdn = run_clock_config_ext_reg[`SCD_RUN_CLOCK_CONFIG_EXT_PWRDN];
			e_osc = run_clock_config_ext_reg[`SCD_RUN_CLOCK_CONFIG_EXT_OSC +: 3];
			e_div = 7'(run_clock_config_ext_reg[`SCD_RUN_CLOCK_CONFIG_EXT_SYSTEM_DIVIDER +: 6]) + 7'h01;
		end else begin
			e_byp = rcc_reg[`SCD_RCC_BYP];
			e_pwrdn = rcc_reg[`SCD_RCC_PWRDN];
			e_osc = {1'b0, rcc_reg[`SCD_RCC_OSC +: 2]};
			e_div = rcc_reg[`SCD_RCC_USEDIV] ? 7'(rcc_reg[`SCD_RCC_SYSTEM_DIVIDER +: 4]) + 7'h01 : 7'h01;
		end
	end
	assign pll_enable_o = ~e_pwrdn;
	assign pll_ref_rtc_o = ovr & (e_osc == `SCD_OSC_RTC);
	assign pll_settings_o = XLAT[crystal_select];

	// relock guard; a repeated crystal value is not a change
	logic pwrdn_q;
	logic crystal_select_chg;
	assign crystal_select_chg = wr_rcc & (crystal_select_new != crystal_select);
	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		unique case (st_reg)
			scd_pkg::SCD_PLL_OFF: begin
				if (!e_pwrdn && pwrdn_q) begin
					st_next = scd_pkg::SCD_PLL_RELOCK;
					cnt_next = RELOCK_LOAD;
				end
			end
			scd_pkg::SCD_PLL_RELOCK: begin
				if (edge_w[0]) begin
					cnt_next = cnt_reg - 16'h0001;
				end
				if (edge_w[0] && cnt_reg == 16'h0001) begin
					st_next = scd_pkg::SCD_PLL_LOCKED;
				end
			end
			scd_pkg::SCD_PLL_LOCKED: st_next = scd_pkg::SCD_PLL_LOCKED;
		endcase
		if (crystal_select_chg && st_reg != scd_pkg::SCD_PLL_OFF) begin
			st_next = scd_pkg::SCD_PLL_RELOCK;
			cnt_next = RELOCK_LOAD;
		end
		if (e_pwrdn) begin
			st_next = scd_pkg::SCD_PLL_OFF;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= scd_pkg::SCD_PLL_OFF;
			cnt_reg <= 16'h0000;
			pwrdn_q <= 1'b1;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			pwrdn_q <= e_pwrdn;
		end
	end
	// oscillator stays in charge until lock, even if pll was selected at once
	assign use_pll_o = ~e_byp & (st_reg == scd_pkg::SCD_PLL_LOCKED);

	// clock dividers run as tick streams on the sampled source edges
	logic [1:0] q4_reg, q4_next;
	logic half_reg, half_next, osc_edge, src_edge, sys_tick;
	logic [6:0] sdiv_reg, sdiv_next;
	logic [4:0] adc_reg, adc_next;
	logic [8:0] pwm_reg, pwm_next, pwm_div;
	scd_pkg::scd_ticks_t tk_reg, tk_next;
	logic [NPERIPH-1:0] pen_reg, pen_next;
	always_comb begin
		unique case (e_osc)
			3'h0: osc_edge = edge_w[0];
			3'h1: osc_edge = edge_w[1];
			3'h2: osc_edge = edge_w[1] & (q4_reg == 2'h3);
			3'h3: osc_edge = edge_w[2];
			`SCD_OSC_RTC: osc_edge = edge_w[3];
			default: osc_edge = edge_w[0]; // unused codes fall back to main
		endcase
		q4_next = edge_w[1] ? q4_reg + 2'h1 : q4_reg;
		half_next = edge_w[4] ? ~half_reg : half_reg;
		src_edge = use_pll_o ? (edge_w[4] & half_reg) : osc_edge;
		sdiv_next = sdiv_reg;
		sys_tick = 1'b0;
		if (src_edge) begin
			sys_tick = (sdiv_reg + 7'h01 >= e_div);
			sdiv_next = sys_tick ? 7'h00 : sdiv_reg + 7'h01;
		end
		adc_next = adc_reg;
		tk_next.adc = 1'b0;
		if (edge_w[4] && !e_pwrdn) begin
			tk_next.adc = (adc_reg == ADC_DIV - 5'h01);
			adc_next = tk_next.adc ? 5'h00 : adc_reg + 5'h01;
		end
		// nine bits so the largest divide by 256 does not wrap to zero
		pwm_div = rcc_reg[`SCD_RCC_PWMEN] ? 9'h002 << rcc_reg[`SCD_RCC_PWM_CLOCK_DIVIDER +: 3] : 9'h001;
		pwm_next = pwm_reg;
		tk_next.pwm = 1'b0;
		if (sys_tick) begin
			tk_next.pwm = (pwm_reg + 9'h001 >= pwm_div);
			pwm_next = tk_next.pwm ? 9'h000 : pwm_reg + 9'h001;
		end
		tk_next.sys = sys_tick;
		pen_next = gate_reg & {NPERIPH{sys_tick}};
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q4_reg <= 2'h0;
			half_reg <= 1'b0;
			sdiv_reg <= 7'h00;
			adc_reg <= 5'h00;
			pwm_reg <= 9'h000;
			tk_reg <= '0;
			pen_reg <= '0;
		end else begin
			q4_reg <= q4_next;
			half_reg <= half_next;
			sdiv_reg <= sdiv_next;
			adc_reg <= adc_next;
			pwm_reg <= pwm_next;
			tk_reg <= tk_next;
			pen_reg <= pen_next;
		end
	end
	assign ticks_o = tk_reg;
	assign periph_clk_en_o = pen_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// checked at the outputs so a wrong field pick shows up
	property p_ovr_byp;
		ovr |-> (pll_enable_o == !run_clock_config_ext_reg[`SCD_RUN_CLOCK_CONFIG_EXT_PWRDN]) && (!run_clock_config_ext_reg[`SCD_RUN_CLOCK_CONFIG_EXT_BYP] || !use_pll_o);
	endproperty
	a_ovr_byp: assert property (p_ovr_byp) else $error("override not taken");
	property p_no_pll_unlocked;
		(st_reg != scd_pkg::SCD_PLL_LOCKED) |-> !use_pll_o;
	endproperty
	a_no_pll_unlocked: assert property (p_no_pll_unlocked) else $error("pll used before lock");
	property p_off_when_pwrdn;
		e_pwrdn |=> (st_reg == scd_pkg::SCD_PLL_OFF) || !$past(e_pwrdn);
	endproperty
	a_off_when_pwrdn: assert property (p_off_when_pwrdn) else $error("pll alive in power down");
	property p_same_crystal_select;
		(wr_rcc && crystal_select_new == crystal_select && st_reg == scd_pkg::SCD_PLL_LOCKED && !e_pwrdn && !ovr)
			|=> (st_reg == scd_pkg::SCD_PLL_LOCKED);
	endproperty
	a_same_crystal_select: assert property (p_same_crystal_select) else $error("relock on same crystal");
	property p_crystal_select_relock;
		(crystal_select_chg && st_reg != scd_pkg::SCD_PLL_OFF && !e_pwrdn) |=> st_reg == scd_pkg::SCD_PLL_RELOCK
			|| $past(wr_go && wb_adr_i == `SCD_OFF_RUN_CLOCK_CONFIG_EXT);
	endproperty
	a_crystal_select_relock: assert property (p_crystal_select_relock) else $error("crystal change missed");
	property p_settings;
		##1 pll_settings_o == XLAT[$past(crystal_select_new)];
	endproperty
	a_settings: assert property (p_settings) else $error("translation stale");
	// a shrinking divisor may leave the count high until the next source edge
	property p_div_bound;
		src_edge |=> (sdiv_reg < e_div) || $changed(e_div);
	endproperty
	a_div_bound: assert property (p_div_bound) else $error("system divider overrun");
	property p_rtc_ref;
		pll_ref_rtc_o == (ovr && run_clock_config_ext_reg[`SCD_RUN_CLOCK_CONFIG_EXT_OSC +: 3] == `SCD_OSC_RTC);
	endproperty
	a_rtc_ref: assert property (p_rtc_ref) else $error("rtc reference wrong");
	property p_pwm_sync;
		ticks_o.pwm |-> ticks_o.sys;
	endproperty
	a_pwm_sync: assert property (p_pwm_sync) else $error("pwm tick off system tick");
	property p_gate;
		|(periph_clk_en_o & ~$past(gate_reg)) == 1'b0;
	endproperty
	a_gate: assert property (p_gate) else $error("gated peripheral clocked");
	c_lock: cover property (st_reg == scd_pkg::SCD_PLL_RELOCK ##1 st_reg == scd_pkg::SCD_PLL_LOCKED);
	c_pll_sys: cover property (use_pll_o && ticks_o.sys);
	c_ovr_div: cover property (ovr && e_div > 7'h10 && ticks_o.sys);
	c_adc: cover property (ticks_o.adc);
endmodule
`default_nettype wire

//--- scd_testbench.sv
// self-checking bench for the clock configuration block
`timescale 1ns/10ps
`default_nettype none
`include "scd_regs.svh"
module testbench;
	logic clk_i, rst_i, cyc, stb, we;
	logic [7:0] adr, oc;
	logic [3:0] sel;
	logic [31:0] dat, dat_o, q, m_rcc;
	logic ack, pll_en, ref_rtc, use_pll;
	logic [13:0] sets, old_sets;
	logic [7:0] pclk;
	scd_pkg::scd_ticks_t tk;
	int n_fail, tests_run, cycles, n, i;
	int i_tab[3] = '{0, 3, 15};
	logic [31:0] rnd;
	scd_clock_config #(.NPERIPH(8), .RELOCK_LOAD(16'h0008)) scd_clock_config_inst (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .main_osc_i(oc[2]), .int_osc_i(oc[4]), .slow_osc_i(oc[5]),
		.rtc_osc_i(oc[6]), .pll_vco_i(oc[3]), .ticks_o(tk), .periph_clk_en_o(pclk), .pll_enable_o(pll_en),
		.pll_ref_rtc_o(ref_rtc), .use_pll_o(use_pll), .pll_settings_o(sets));
	// free-running oscillators: main 8 clk, pll 16 clk periods
	initial begin
		clk_i = 0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		oc <= oc + 8'h01;
		cycles++;
		if (cycles == 60000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
			n_fail++;
		end
	endtask
	// classic cycle: hold everything until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// interval in clk cycles between two ticks, first two discarded to let a new setting settle
	task automatic gap(input int k, output int iv);
		int j;
		for (j = 0; j < 3; j++) begin
			iv = 0;
			do begin
				@(posedge clk_i);
				iv++;
			end while (((k == 0) ? tk.sys : (k == 1) ? tk.adc : tk.pwm) !== 1'b1 && iv < 3000);
		end
	endtask
	task automatic tally_and_finish();
		if (n_fail == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		{cyc, stb, we, adr, dat, sel, oc, n_fail, tests_run, cycles} = '0;
		rnd = 32'd54314;
		rst_i = 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		check(pll_en, 0);
		check(use_pll, 0);
		wb(0, `SCD_OFF_RCC, 0, 4'hf);
		check(q, `SCD_RCC_RST);
		wb(0, `SCD_OFF_RUN_CLOCK_CONFIG_EXT, 0, 4'hf);
		check(q, `SCD_RUN_CLOCK_CONFIG_EXT_RST);
		wb(1, 8'h20, 32'hffff_ffff, 4'hf);
		wb(0, 8'h20, 0, 4'hf);
		check(q, 0);
		// random lanes and data through the writable mask
		m_rcc = `SCD_RCC_RST;
		rnd = xs(rnd);
		wb(1, `SCD_OFF_RCC, rnd, rnd[3:0]);
		for (i = 0; i < 4; i++)
			if (rnd[i])
				m_rcc[8*i+:8] = (m_rcc[8*i+:8] & ~(`SCD_RCC_WMASK >> (8*i))) | (rnd[8*i+:8] & (`SCD_RCC_WMASK >> (8*i)));
		wb(0, `SCD_OFF_RCC, 0, 4'hf);
		check(q, m_rcc);
		// oscillator path, base divider field plus one
		foreach (i_tab[k]) begin
			wb(1, `SCD_OFF_RCC, 32'h0040_2ac0 | (i_tab[k] << 23), 4'hf);
			gap(0, n);
			check(n, 8 * (i_tab[k] + 1));
		end
		// other oscillator codes: internal 32, internal/4 128, slow 64 clk
		for (i = 1; i < 4; i++) begin
			wb(1, `SCD_OFF_RCC, 32'h0040_2ac0 | (i << 4), 4'hf);
			gap(0, n);
			check(n, (i == 1) ? 32 : (i == 2) ? 128 : 64);
		end
		// override takes the six-bit divider
		for (i = 1; i < 64; i += 62) begin
			wb(1, `SCD_OFF_RUN_CLOCK_CONFIG_EXT, 32'h8000_2800 | (i << 23), 4'hf);
			gap(0, n);
			check(n, 8 * (i + 1));
		end
		wb(1, `SCD_OFF_RUN_CLOCK_CONFIG_EXT, 32'h8000_2870, 4'hf);
		check(ref_rtc, 1);
		wb(1, `SCD_OFF_RUN_CLOCK_CONFIG_EXT, `SCD_RUN_CLOCK_CONFIG_EXT_RST, 4'hf);
		check(ref_rtc, 0);
		// pwm divides the system tick by 2<<n
		for (i = 0; i < 2; i++) begin
			wb(1, `SCD_OFF_RCC, 32'h0050_2ac0 | (i << 17), 4'hf);
			gap(2, n);
			check(n, 8 * (2 << i));
		end
		rnd = xs(rnd);
		wb(1, `SCD_OFF_GATE, {24'h0, rnd[7:0]}, 4'hf);
		gap(0, n);
		check(pclk, rnd[7:0]);
		// enable and select pll in one write; crystal in pll range, system clock 50 MHz
		wb(1, `SCD_OFF_RCC, 32'h01c0_02c0, 4'hf);
		check(use_pll, 0);
		check(pll_en, 1);
		n = 0;
		while (use_pll !== 1'b1 && n < 1000) begin
			@(posedge clk_i);
			n++;
		end
		check(n >= 56 && n < 300, 1);
		gap(0, n);
		check(n, 16 * 2 * 4);
		gap(1, n);
		check(n, 16 * 25);
		wb(1, `SCD_OFF_RCC, 32'h01c0_02c0, 4'hf);
		repeat (4) @(posedge clk_i);
		check(use_pll, 1);
		old_sets = sets;
		wb(1, `SCD_OFF_RCC, 32'h01c0_0300, 4'hf);
		repeat (4) @(posedge clk_i);
		check(use_pll, 0);
		check(sets != old_sets, 1);
		wb(0, `SCD_OFF_STAT, 0, 4'hf);
		check(q, 32'h0000_0002);
		wb(0, `SCD_OFF_XLAT, 0, 4'hf);
		check(q[13:0], sets);
		// override powers the pll down although the base register has it on
		wb(1, `SCD_OFF_RUN_CLOCK_CONFIG_EXT, 32'h8000_2800, 4'hf);
		check(pll_en, 0);
		check(use_pll, 0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
